// File: rtl/sac_pkg.sv
// Package for the successive-approximation converter control block.
// Assumes a 200 MHz pclk and a 32-bit APB register bus with 8-bit offsets.
package sac_pkg;

    // Clock and instruction timing.
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned INSTR_TIME_NS  = 20;
    localparam int unsigned INSTR_CYCLES   = (INSTR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL_ZERO   = 8'h00;
    localparam logic [7:0] OFS_CTRL_ONE    = 8'h04;
    localparam logic [7:0] OFS_RES_HIGH    = 8'h08;
    localparam logic [7:0] OFS_RES_LOW     = 8'h0C;
    localparam logic [7:0] OFS_FLAG        = 8'h10;
    localparam logic [7:0] OFS_IRQ_CTRL    = 8'h14;

    // Field positions in converter_control_zero.
    localparam int unsigned ENABLE_POS     = 0;
    localparam int unsigned GO_POS         = 1;
    localparam int unsigned CHAN_LSB       = 2;
    // Field positions in converter_control_one.
    localparam int unsigned PREF_LSB       = 0;
    localparam int unsigned NREF_POS       = 3;
    localparam int unsigned CLKSEL_LSB     = 4;
    localparam int unsigned FMT_POS        = 7;
    // Field positions in the flag and interrupt control registers.
    localparam int unsigned DONE_FLAG_POS  = 0;
    localparam int unsigned IRQ_EN_POS     = 0;
    localparam int unsigned PERIPH_EN_POS  = 1;
    localparam int unsigned GLOBAL_EN_POS  = 2;

    // Reset values.
    localparam logic [7:0] CTRL_RESET      = 8'h00;

    // Positive reference codes.
    localparam logic [2:0] PREF_EXT_PIN    = 3'h0;
    localparam logic [2:0] PREF_SUPPLY     = 3'h1;
    localparam logic [2:0] PREF_FIXED_LOW  = 3'h2;
    localparam logic [2:0] PREF_FIXED_HIGH = 3'h3;
    localparam logic [2:0] PREF_GROUND     = 3'h4;

    // Conversion clock select codes; any code ending in 11 picks the RC source.
    localparam logic [2:0] CS_DIV2         = 3'b000;
    localparam logic [2:0] CS_DIV4         = 3'b100;
    localparam logic [2:0] CS_DIV8         = 3'b001;
    localparam logic [2:0] CS_DIV16        = 3'b101;
    localparam logic [2:0] CS_DIV32        = 3'b010;
    localparam logic [2:0] CS_DIV64        = 3'b110;
    localparam logic [1:0] CS_RC_LOW_BITS  = 2'b11;

    // Last count of a half conversion period, in pclk cycles minus one.
    localparam logic [4:0] HALF_DIV2       = 5'h00;
    localparam logic [4:0] HALF_DIV4       = 5'h01;
    localparam logic [4:0] HALF_DIV8       = 5'h03;
    localparam logic [4:0] HALF_DIV16      = 5'h07;
    localparam logic [4:0] HALF_DIV32      = 5'h0F;
    localparam logic [4:0] HALF_DIV64      = 5'h1F;

    // Conversion sequence: 23 half periods make 11.5 conversion periods.
    localparam int unsigned RESULT_BITS    = 10;
    localparam logic [4:0] HALF_FIRST_BIT  = 5'h04;
    localparam logic [4:0] HALF_LAST       = 5'h16;
    localparam logic [3:0] MSB_INDEX       = 4'h9;
    localparam logic [9:0] SAR_START       = 10'h200;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV  = 2'b11
    } sac_state_t;

    // Everything the analog front end needs from the control logic.
    typedef struct packed {
        logic [5:0] channel;
        logic [2:0] pos_ref;
        logic       neg_ref;
        logic       powered;
        logic       sampling;
        logic [9:0] trial;
    } sac_analog_t;

endpackage : sac_pkg

// File: rtl/sac_conv_ctrl.sv
// Control logic of a 10-bit successive-approximation converter with an APB register file.
// Assumes the analog multiplexer, references and comparator sit outside and that all
// inputs, including the RC half-period tick, are synchronous to pclk.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module sac_conv_ctrl
(
    input  wire logic                pclk,               // System clock, 200 MHz.
    input  wire logic                presetn,            // Asynchronous reset, active low.
    input  wire logic                clk_en,             // Freezes all state while low.
    input  wire logic                psel,               // APB select.
    input  wire logic                penable,            // APB access phase.
    input  wire logic                pwrite,             // APB direction, high for write.
    input  wire logic [7:0]          paddr,              // APB byte address.
    input  wire logic [31:0]         pwdata,             // APB write data.
    output logic      [31:0]         prdata,             // APB read data.
    output logic                     pready,             // APB ready.
    output logic                     pslverr,            // APB error on unmapped address.
    input  wire logic                rc_half_tick,       // One pulse per half RC conversion period.
    input  wire logic                comparator_high,    // Input is at or above the trial level.
    input  wire logic                sleep_active,       // Core is in sleep.
    output sac_pkg::sac_analog_t     analog,             // Controls for the analog front end.
    output logic                     wake_req,           // Wake pulse to the core.
    output logic                     branch_to_handler,  // Wake goes to the interrupt handler.
    output logic                     resume_inline       // Wake resumes after the sleep.
);
    import sac_pkg::*;

    logic [5:0]  chan_ff;
    logic        enable_ff;
    logic        go_ff;
    logic [2:0]  pref_ff;
    logic        nref_ff;
    logic [2:0]  clksel_ff;
    logic        fmt_ff;
    logic [7:0]  res_high_ff;
    logic [7:0]  res_low_ff;
    logic        flag_ff;
    logic        irq_en_ff;
    logic        periph_en_ff;
    logic        global_en_ff;
    sac_state_t  state_ff;
    logic [3:0]  dly_ff;
    logic [4:0]  div_ff;
    logic [4:0]  half_ff;
    logic [9:0]  sar_ff;
    logic [3:0]  idx_ff;
    logic        last_bit_ff;
    logic        pwr_down_ff;
    logic        wake_ff;
    logic        branch_ff;
    logic        resume_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;

    logic        acc_take;
    logic        wr_take;
    logic        ctrl0_wr;
    logic        rc_sel;
    logic [4:0]  div_last;
    logic        conv_tick;
    logic        decide;
    logic        done;
    logic        start_req;
    logic        abort_sw;
    logic        abort_hw;
    logic        flag_clr;
    logic [9:0]  nxt_sar;
    logic [9:0]  unresolved;
    logic [9:0]  partial;
    logic [31:0] rd_val;
    logic        rd_hit;

    // Packs a 10-bit result into the high and low byte pair; unused bits stay zero.
    function automatic logic [15:0] pack_result(input logic [9:0] r, input logic left);
        logic [15:0] v;
        v = 16'h0000;
        if (left)
        begin
            v = {r, 6'b00_0000};
        end
        else
        begin
            v = {6'b00_0000, r};
        end
        return v;
    endfunction : pack_result

    // APB decode: one wait state so read data always comes from a flip-flop.
    assign acc_take = psel & penable & pready_ff;
    assign wr_take  = acc_take & pwrite;
    assign ctrl0_wr = wr_take && (paddr == OFS_CTRL_ZERO);
    assign flag_clr = wr_take && (paddr == OFS_FLAG) && pwdata[DONE_FLAG_POS];

    // Conversion clock source and divider period.
    assign rc_sel = (clksel_ff[1:0] == CS_RC_LOW_BITS);
    always_comb
    begin
        case (clksel_ff)
            CS_DIV2:  div_last = HALF_DIV2;
            CS_DIV4:  div_last = HALF_DIV4;
            CS_DIV8:  div_last = HALF_DIV8;
            CS_DIV16: div_last = HALF_DIV16;
            CS_DIV32: div_last = HALF_DIV32;
            CS_DIV64: div_last = HALF_DIV64;
            default:  div_last = HALF_DIV2;
        endcase
    end

    // Sequence events. A half tick advances the step counter; even steps from four on resolve a bit.
    assign conv_tick = (state_ff == ST_CONV) && (rc_sel ? rc_half_tick : (div_ff == div_last));
    assign decide    = conv_tick && (half_ff >= HALF_FIRST_BIT) && !half_ff[0];
    assign done      = conv_tick && (half_ff == HALF_LAST);
    assign start_req = ctrl0_wr && pwdata[GO_POS] && enable_ff && (state_ff == ST_IDLE);
    assign abort_sw  = ctrl0_wr && !pwdata[GO_POS] && (state_ff != ST_IDLE) && !done;
    // Sleep on a divided clock, or switching the converter off, kills the conversion outright.
    assign abort_hw  = (state_ff != ST_IDLE) && !done
                       && ((sleep_active && !rc_sel) || (ctrl0_wr && !pwdata[ENABLE_POS]));

    // Next trial word: keep the decided bit, then try the next lower bit.
    always_comb
    begin
        nxt_sar = sar_ff;
        nxt_sar[idx_ff] = comparator_high;
        if (idx_ff != 4'h0)
        begin
            nxt_sar[idx_ff - 4'h1] = 1'b1;
        end
    end

    // Partial result: unresolved bits copy the last resolved bit.
    assign unresolved = 10'((11'h002 << idx_ff) - 11'h001);
    assign partial    = (sar_ff & ~unresolved) | (last_bit_ff ? unresolved : 10'h000);

    // Control register zero: channel, enable and the go/busy bit.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_ff   <= CTRL_RESET[5:0];
            enable_ff <= 1'b0;
            go_ff     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ctrl0_wr)
            begin
                chan_ff   <= pwdata[CHAN_LSB +: 6];
                enable_ff <= pwdata[ENABLE_POS];
            end
            if (done || abort_sw || abort_hw)
            begin
                go_ff <= 1'b0;
            end
            else if (start_req)
            begin
                go_ff <= 1'b1;
            end
        end
    end

    // Control register one: references, clock select and result format.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pref_ff   <= CTRL_RESET[2:0];
            nref_ff   <= 1'b0;
            clksel_ff <= CTRL_RESET[2:0];
            fmt_ff    <= 1'b0;
        end
        else if (clk_en && wr_take && (paddr == OFS_CTRL_ONE))
        begin
            pref_ff   <= pwdata[PREF_LSB +: 3];
            nref_ff   <= pwdata[NREF_POS];
            clksel_ff <= pwdata[CLKSEL_LSB +: 3];
            fmt_ff    <= pwdata[FMT_POS];
        end
    end

    // Interrupt enables, kept here because the block drives the wake decision itself.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_en_ff    <= 1'b0;
            periph_en_ff <= 1'b0;
            global_en_ff <= 1'b0;
        end
        else if (clk_en && wr_take && (paddr == OFS_IRQ_CTRL))
        begin
            irq_en_ff    <= pwdata[IRQ_EN_POS];
            periph_en_ff <= pwdata[PERIPH_EN_POS];
            global_en_ff <= pwdata[GLOBAL_EN_POS];
        end
    end

    // Done flag: set on every completion, cleared only by a software write of one.
    // A completion in the clearing cycle wins so no event is lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (done)
            begin
                flag_ff <= 1'b1;
            end
            else if (flag_clr)
            begin
                flag_ff <= 1'b0;
            end
        end
    end

    // Sequencer state: idle, the one-instruction RC start delay, and conversion.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= ST_IDLE;
            dly_ff   <= 4'h0;
        end
        else if (clk_en)
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    dly_ff <= 4'h0;
                    if (start_req)
                    begin
                        state_ff <= rc_sel ? ST_DELAY : ST_CONV;
                    end
                end
                ST_DELAY:
                begin
                    dly_ff <= dly_ff + 4'h1;
                    if (abort_sw || abort_hw)
                    begin
                        state_ff <= ST_IDLE;
                    end
                    else if (dly_ff == 4'(INSTR_CYCLES - 1))
                    begin
                        state_ff <= ST_CONV;
                    end
                end
                ST_CONV:
                begin
                    if (done || abort_sw || abort_hw)
                    begin
                        state_ff <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Divider and half-period step counter; both restart with each conversion.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_ff  <= 5'h00;
            half_ff <= 5'h00;
        end
        else if (clk_en)
        begin
            if (state_ff != ST_CONV)
            begin
                div_ff  <= 5'h00;
                half_ff <= 5'h00;
            end
            else
            begin
                div_ff <= (rc_sel || div_ff == div_last) ? 5'h00 : div_ff + 5'h01;
                if (conv_tick)
                begin
                    half_ff <= half_ff + 5'h01;
                end
            end
        end
    end

    // Successive approximation register, bit pointer and last decided bit.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sar_ff      <= 10'h000;
            idx_ff      <= MSB_INDEX;
            last_bit_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start_req)
            begin
                sar_ff      <= SAR_START;
                idx_ff      <= MSB_INDEX;
                last_bit_ff <= 1'b0;
            end
            else if (decide)
            begin
                sar_ff      <= nxt_sar;
                last_bit_ff <= comparator_high;
                if (idx_ff != 4'h0)
                begin
                    idx_ff <= idx_ff - 4'h1;
                end
            end
        end
    end

    // Result pair: full result on completion, filled partial result on software abort.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_high_ff <= 8'h00;
            res_low_ff  <= 8'h00;
        end
        else if (clk_en)
        begin
            if (done)
            begin
                {res_high_ff, res_low_ff} <= pack_result(nxt_sar, fmt_ff);
            end
            else if (abort_sw)
            begin
                {res_high_ff, res_low_ff} <= pack_result(partial, fmt_ff);
            end
        end
    end

    // Power-down while asleep; the enable bit is left alone and power returns on waking.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwr_down_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            // Power goes down even if the last step completes in the sleep cycle itself.
            if (sleep_active && !rc_sel && (state_ff != ST_IDLE))
            begin
                pwr_down_ff <= 1'b1;
            end
            else if (done && sleep_active && !irq_en_ff && rc_sel)
            begin
                pwr_down_ff <= 1'b1;
            end
            else if (!sleep_active)
            begin
                pwr_down_ff <= 1'b0;
            end
        end
    end

    // Wake and resume decision, registered so each is a clean one-cycle pulse.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_ff   <= 1'b0;
            branch_ff <= 1'b0;
            resume_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            wake_ff   <= done && sleep_active && irq_en_ff;
            branch_ff <= done && sleep_active && irq_en_ff && periph_en_ff && global_en_ff;
            resume_ff <= done && sleep_active && irq_en_ff && !(periph_en_ff && global_en_ff);
        end
    end

    // Read multiplexer; reserved bits read zero.
    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == OFS_CTRL_ZERO)
        begin
            rd_val[7:0] = {chan_ff, go_ff, enable_ff};
        end
        else if (paddr == OFS_CTRL_ONE)
        begin
            rd_val[7:0] = {fmt_ff, clksel_ff, nref_ff, pref_ff};
        end
        else if (paddr == OFS_RES_HIGH)
        begin
            rd_val[7:0] = res_high_ff;
        end
        else if (paddr == OFS_RES_LOW)
        begin
            rd_val[7:0] = res_low_ff;
        end
        else if (paddr == OFS_FLAG)
        begin
            rd_val[DONE_FLAG_POS] = flag_ff;
        end
        else if (paddr == OFS_IRQ_CTRL)
        begin
            rd_val[2:0] = {global_en_ff, periph_en_ff, irq_en_ff};
        end
        else
        begin
            rd_hit = 1'b0;
        end
    end

    // APB answer: ready rises in the second access cycle and drops after the handshake.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            if (psel && penable && !pready_ff)
            begin
                pready_ff  <= 1'b1;
                pslverr_ff <= !rd_hit;
                prdata_ff  <= pwrite ? 32'h0000_0000 : rd_val;
            end
            else
            begin
                pready_ff  <= 1'b0;
                pslverr_ff <= 1'b0;
            end
        end
    end

    // Outputs.
    assign prdata            = prdata_ff;
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign wake_req          = wake_ff;
    assign branch_to_handler = branch_ff;
    assign resume_inline     = resume_ff;
    assign analog.channel    = chan_ff;
    assign analog.pos_ref    = pref_ff;
    assign analog.neg_ref    = nref_ff;
    assign analog.powered    = enable_ff && !pwr_down_ff;
    assign analog.sampling   = enable_ff && !pwr_down_ff && (state_ff != ST_CONV);
    assign analog.trial      = sar_ff;

    chk_start_sets_go: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && start_req) |=> (go_ff && state_ff != ST_IDLE))
        else $error("Start request did not set busy.");

    chk_done_clears_go: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && done) |=> (!go_ff && flag_ff && state_ff == ST_IDLE))
        else $error("Completion did not clear busy and set flag.");

    chk_flag_stays_set: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_ff && !(clk_en && flag_clr)) |=> flag_ff)
        else $error("Done flag cleared without software.");

    chk_wake_on_done: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && done && sleep_active && irq_en_ff) |=> (wake_req && (branch_to_handler != resume_inline)))
        else $error("Completion in sleep did not wake.");

    chk_branch_needs_enables: assert property (@(posedge pclk) disable iff (!presetn)
        branch_to_handler |-> (wake_req && $past(global_en_ff) && $past(periph_en_ff)))
        else $error("Branch without all enables.");

    chk_sleep_abort_off: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && sleep_active && !rc_sel && state_ff == ST_CONV) |=> (state_ff == ST_IDLE && !analog.powered))
        else $error("Sleep on divided clock did not abort.");

    chk_rc_start_delay: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && start_req && rc_sel) |=> (state_ff == ST_DELAY))
        else $error("RC start skipped the instruction delay.");

    chk_right_format_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && done && !fmt_ff) |=> (res_high_ff[7:2] == 6'h00 && res_low_ff == $past(nxt_sar[7:0])))
        else $error("Right-justified result misplaced.");

endmodule : sac_conv_ctrl

`default_nettype wire

// File: tb/sac_cmp_model.sv
// Comparator and held input of the converter's analog side.
// Assumes the trial word changes only just after rising edges of pclk.
`timescale 1ns/1ps
`default_nettype none

module sac_cmp_model
(
    input  wire logic                 pclk,     // System clock.
    input  wire sac_pkg::sac_analog_t analog,   // Controls from the block.
    input  wire logic [9:0]           vin,      // Held input level.
    output logic                      cmp_high  // Comparator decision.
);
    import sac_pkg::*;
    logic last_ff;

    // Unpowered, the output toggles so a stale decision is never read as a real one.
    always_ff @(posedge pclk)
    begin
        last_ff <= cmp_high;
    end
    assign cmp_high = analog.powered ? (vin >= analog.trial) : ~last_ff;

endmodule : sac_cmp_model
`default_nettype wire

// File: tb/testbench.sv
// Register-level bench for the converter control block.
// Assumes the partner comparator model; runs both divided and RC conversion clocks.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import sac_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        sleep_active = 0, pready, pslverr, cmp_high, wake, er;
    logic        ce = 1, rc_tick = 0, branch, resume;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [9:0]  vin = 0;
    sac_analog_t analog;
    int          error_cnt = 0, num_checks = 0, cyc = 0;

    sac_conv_ctrl uut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rc_half_tick(rc_tick), .comparator_high(cmp_high), .sleep_active(sleep_active),
        .analog(analog), .wake_req(wake), .branch_to_handler(branch), .resume_inline(resume));
    sac_cmp_model cmp (.pclk(pclk), .analog(analog), .vin(vin), .cmp_high(cmp_high));

    // A 5 ns clock; the cycle counter cuts a hang short.
    always #2.5 pclk = ~pclk;
    // The RC source runs free, so its half-period tick pulses every other cycle.
    always @(posedge pclk)
    begin
        rc_tick <= ~rc_tick;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rdc

    // Start a conversion, poll go, then read the result pair and the flag.
    task automatic conv(input logic [7:0] c1, input logic [9:0] v, input logic [7:0] h, input logic [7:0] l);
        vin <= v;
        apb(1'b1, OFS_CTRL_ONE, {24'h0000_00, c1});
        apb(1'b1, OFS_CTRL_ZERO, 32'h0000_0047);
        repeat (100)
        begin
            apb(1'b0, OFS_CTRL_ZERO, 32'h0000_0000);
            if (rd[GO_POS] === 1'b0)
                break;
        end
        chk("go", 32'h0000_0000, rd[GO_POS]);
        rdc(OFS_RES_HIGH, {24'h0000_00, h}, "res_high");
        rdc(OFS_RES_LOW, {24'h0000_00, l}, "res_low");
        rdc(OFS_FLAG, 32'h0000_0001, "flag");
        rdc(OFS_FLAG, 32'h0000_0001, "flag_kept");
        apb(1'b1, OFS_FLAG, 32'h0000_0001);
        rdc(OFS_FLAG, 32'h0000_0000, "flag_clr");
    endtask : conv

    // RC conversion in sleep: one-instruction start delay, then wake, branch or power-down.
    task automatic rcrun(input logic [2:0] irq, input logic wk, input logic br);
        apb(1'b1, OFS_IRQ_CTRL, {29'h0000_0000, irq});
        apb(1'b1, OFS_CTRL_ZERO, 32'h0000_0047);
        sleep_active <= 1'b1;
        @(posedge pclk);
        chk("rc_delay", 32'h0000_0001, analog.sampling);
        repeat (INSTR_CYCLES) @(posedge pclk);
        chk("rc_conv", 32'h0000_0000, analog.sampling);
        repeat (100)
        begin
            @(posedge pclk);
            if (wake === 1'b1)
                break;
        end
        chk("wake", wk, wake);
        chk("branch", br, branch);
        chk("resume", wk & !br, resume);
        chk("rc_powered", wk, analog.powered);
        sleep_active <= 1'b0;
        rdc(OFS_CTRL_ZERO, 32'h0000_0045, "enable_kept");
        rdc(OFS_RES_LOW, 32'h0000_0055, "rc_low");
        apb(1'b1, OFS_FLAG, 32'h0000_0001);
    endtask : rcrun

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFS_CTRL_ZERO, CTRL_RESET, "ctrl_zero");
        rdc(OFS_CTRL_ONE, CTRL_RESET, "ctrl_one");
        rdc(8'h40, 32'h0000_0000, "unmapped");
        chk("pslverr", 32'h0000_0001, er);
        // Go in the enabling write must be ignored; enable goes first.
        apb(1'b1, OFS_CTRL_ZERO, 32'h0000_0047);
        rdc(OFS_CTRL_ZERO, 32'h0000_0045, "go_ignored");
        chk("channel", 32'h0000_0011, analog.channel);
        repeat (40) @(posedge pclk);
        conv(8'h01, 10'h2A5, 8'h02, 8'hA5);
        chk("pos_ref", 32'h0000_0001, analog.pos_ref);
        conv(8'h89, 10'h2A5, 8'hA9, 8'h40);
        chk("neg_ref", 32'h0000_0001, analog.neg_ref);
        // Abort a slow conversion after one resolved bit; a frozen stretch must not advance it.
        vin <= 10'h200;
        apb(1'b1, OFS_CTRL_ONE, 32'h0000_0060);
        apb(1'b1, OFS_CTRL_ZERO, 32'h0000_0047);
        ce <= 1'b0;
        repeat (300) @(posedge pclk);
        ce <= 1'b1;
        repeat (200) @(posedge pclk);
        apb(1'b1, OFS_CTRL_ZERO, 32'h0000_0045);
        rdc(OFS_RES_HIGH, 32'h0000_0003, "part_high");
        rdc(OFS_RES_LOW, 32'h0000_00FF, "part_low");
        // Sleep on a divided clock aborts and powers down; enable stays.
        apb(1'b1, OFS_CTRL_ZERO, 32'h0000_0047);
        repeat (20) @(posedge pclk);
        sleep_active <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("powered", 32'h0000_0000, analog.powered);
        apb(1'b0, OFS_CTRL_ZERO, 32'h0000_0000);
        chk("enable", 32'h0000_0001, rd[ENABLE_POS]);
        sleep_active <= 1'b0;
        // RC clock in sleep: wake to handler, wake inline, then no wake and power-down.
        vin <= 10'h155;
        apb(1'b1, OFS_CTRL_ONE, 32'h0000_0030);
        rcrun(3'h7, 1'b1, 1'b1);
        rcrun(3'h3, 1'b1, 1'b0);
        rcrun(3'h4, 1'b0, 1'b0);
        test_done();
    end

endmodule : testbench
`default_nettype wire
